// ===== core/sebs_cfg.svh
// Constants for the servo enable and brake sequencer
// Functional notes
// - Ignore servo enable for 2 s after power-up
// - Power stage on, ready 20 ms later
// - Drive reset holds power stage off
// - Open estop: dynamic brake and warning flag
// - Resume at once when estop warning clears
// - DD1D selects brake interlock, drops zero speed
// - Programmable brake delay in milliseconds
// - Servo-off keeps lock for brake delay, then coasts
// - Alarm: power stage off, dynamic brake on
// - Servo-off without brake: power stage off, coast
`ifndef SEBS_CFG_SVH
`define SEBS_CFG_SVH

`define SEBS_CLK_MHZ        100
`define SEBS_MS_NS          1000000
`define SEBS_CLK_NS         10
`define SEBS_HOLDOFF_MS     2000
`define SEBS_READY_MS       20
`define SEBS_MS_CYC         (`SEBS_MS_NS / `SEBS_CLK_NS)
`define SEBS_HOLDOFF_CYC    (`SEBS_HOLDOFF_MS * `SEBS_MS_CYC)
`define SEBS_READY_CYC      (`SEBS_READY_MS * `SEBS_MS_CYC)

`define SEBS_ADDR_W         8
`define SEBS_OFF_FUNC_SEL   8'h00
`define SEBS_OFF_BRAKE_DLY  8'h04
`define SEBS_OFF_STATUS     8'h08
`define SEBS_OFF_IRQ_STAT   8'h0c
`define SEBS_OFF_IRQ_MASK   8'h10

`define SEBS_FUNC_MBR       16'hdd1d
`define SEBS_FUNC_SEL_RST   16'h0000
`define SEBS_BRAKE_DLY_RST  16'h0000
`define SEBS_IRQ_MASK_RST   4'h0

`define SEBS_IRQ_ESTOP      0
`define SEBS_IRQ_ALARM      1
`define SEBS_IRQ_READY      2
`define SEBS_IRQ_COAST      3
`define SEBS_IRQ_N          4

`define SEBS_STAT_BASE      3
`define SEBS_STAT_READY     4
`define SEBS_STAT_MBR       5
`define SEBS_STAT_DYN       6
`define SEBS_STAT_WARN      7
`define SEBS_STAT_ALARM     8

`endif

// ===== core/sebs_pkg.sv
// Types for the servo enable and brake sequencer
`default_nettype none
package sebs_pkg;
  typedef enum logic [2:0] {
    SEBS_ST_HOLDOFF,
    SEBS_ST_OFF,
    SEBS_ST_ARM,
    SEBS_ST_RUN,
    SEBS_ST_BRAKE
  } sebs_state_t;
endpackage
`default_nettype wire

// ===== core/sebs_timer.sv
// Loadable down counter with tick enable
`default_nettype none
module sebs_timer #(
  parameter int W = 28
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  output logic              expired
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (tick && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // A load in flight masks a stale zero
  assign expired = (cnt_reg == '0) && !load;
endmodule
`default_nettype wire

// ===== core/sebs_top.sv
// Servo enable, power stage and brake interlock sequencer
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`include "sebs_cfg.svh"
`default_nettype none
module sebs_top #(
  parameter int HOLDOFF_CYC = `SEBS_HOLDOFF_CYC,
  parameter int READY_CYC   = `SEBS_READY_CYC,
  parameter int MS_CYC      = `SEBS_MS_CYC,
  parameter int TW          = 28,
  parameter int BDW         = 16
) (
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire logic                   servo_enable_in,
  input  wire logic                   drive_reset_in,
  input  wire logic                   estop_in,
  input  wire logic                   alarm_in,
  input  wire logic                   zero_speed_in,
  input  wire logic [`SEBS_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  output logic                        base_enable_out,
  output logic                        ready_out,
  output logic                        dyn_brake_out,
  output logic                        estop_warning,
  output logic                        brake_interlock_out,
  output logic                        zero_speed_out,
  output logic                        irq
);
  localparam logic [TW-1:0] HOLD_LD  = TW'(HOLDOFF_CYC);
  localparam logic [TW-1:0] READY_LD = TW'(READY_CYC);
  localparam logic [TW-1:0] MS_LD    = TW'(MS_CYC - 1);

  sebs_pkg::sebs_state_t st_reg;
  sebs_pkg::sebs_state_t st_next;

  logic [15:0]            func_sel_reg;
  logic [BDW-1:0]         brake_dly_reg;
  logic [`SEBS_IRQ_N-1:0] irq_stat_reg;
  logic [`SEBS_IRQ_N-1:0] irq_mask_reg;
  logic [`SEBS_IRQ_N-1:0] irq_ev;
  logic [TW-1:0]          pre_reg;
  logic [TW-1:0]          t_val;
  logic                   t_load;
  logic                   t_tick;
  logic                   t_exp;
  logic                   ms_tick;
  logic                   hold_loaded_reg;
  logic                   mbr_sel;
  logic                   fault;
  logic                   base_next;
  logic                   ready_next;
  logic                   mbr_next;
  logic                   base_reg;
  logic                   ready_reg;
  logic                   dyn_reg;
  logic                   warn_reg;
  logic                   mbr_reg;
  logic                   zsp_reg;
  logic                   alarm_reg;

  // Selection is live at once; no power cycle needed here
  assign mbr_sel = (func_sel_reg == `SEBS_FUNC_MBR);
  // Estop is active when the input is open
  assign fault = alarm_in || !estop_in || drive_reset_in;

  // Millisecond prescaler, restarted when the brake delay starts
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= '0;
    end else if (t_load || pre_reg == '0) begin
      pre_reg <= MS_LD;
    end else begin
      pre_reg <= pre_reg - 1'b1;
    end
  end
  assign ms_tick = (pre_reg == '0) && !t_load;

  // Brake delay counts milliseconds, everything else counts cycles
  assign t_tick = (st_reg == sebs_pkg::SEBS_ST_BRAKE) ? ms_tick : 1'b1;

  sebs_timer #(
    .W (TW)
  ) u_timer (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .load     (t_load),
    .load_val (t_val),
    .tick     (t_tick),
    .expired  (t_exp)
  );

  always_comb begin
    st_next = st_reg;
    t_load  = 1'b0;
    t_val   = '0;
    unique case (st_reg)
      sebs_pkg::SEBS_ST_HOLDOFF: begin
        if (!hold_loaded_reg) begin
          t_load = 1'b1;
          t_val  = HOLD_LD;
        end else if (t_exp) begin
          st_next = sebs_pkg::SEBS_ST_OFF;
        end
      end
      sebs_pkg::SEBS_ST_OFF: begin
        // Run commands left on during estop restart the motor here
        if (servo_enable_in && !fault) begin
          st_next = sebs_pkg::SEBS_ST_ARM;
          t_load  = 1'b1;
          t_val   = READY_LD;
        end
      end
      sebs_pkg::SEBS_ST_ARM: begin
        if (fault || !servo_enable_in) begin
          st_next = sebs_pkg::SEBS_ST_OFF;
        end else if (t_exp) begin
          st_next = sebs_pkg::SEBS_ST_RUN;
        end
      end
      sebs_pkg::SEBS_ST_RUN: begin
        if (fault) begin
          st_next = sebs_pkg::SEBS_ST_OFF;
        end else if (!servo_enable_in && mbr_sel) begin
          st_next = sebs_pkg::SEBS_ST_BRAKE;
          t_load  = 1'b1;
          t_val   = TW'(brake_dly_reg);
        end else if (!servo_enable_in) begin
          st_next = sebs_pkg::SEBS_ST_OFF;
        end
      end
      sebs_pkg::SEBS_ST_BRAKE: begin
        // Servo enable returning mid delay still ends in a coast
        if (fault || t_exp) begin
          st_next = sebs_pkg::SEBS_ST_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg          <= sebs_pkg::SEBS_ST_HOLDOFF;
      hold_loaded_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (st_reg == sebs_pkg::SEBS_ST_HOLDOFF) begin
        hold_loaded_reg <= 1'b1;
      end
    end
  end

  assign base_next  = (st_next == sebs_pkg::SEBS_ST_ARM) || (st_next == sebs_pkg::SEBS_ST_RUN)
                      || (st_next == sebs_pkg::SEBS_ST_BRAKE);
  assign ready_next = (st_next == sebs_pkg::SEBS_ST_RUN);
  // Brake released only while fully locked; drops first at servo-off
  assign mbr_next   = mbr_sel && (st_next == sebs_pkg::SEBS_ST_RUN);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      base_reg  <= 1'b0;
      ready_reg <= 1'b0;
      mbr_reg   <= 1'b0;
      zsp_reg   <= 1'b0;
      dyn_reg   <= 1'b0;
      warn_reg  <= 1'b0;
      alarm_reg <= 1'b0;
    end else begin
      base_reg  <= base_next;
      ready_reg <= ready_next;
      mbr_reg   <= mbr_next;
      zsp_reg   <= !mbr_sel && zero_speed_in;
      dyn_reg   <= alarm_in || !estop_in;
      warn_reg  <= !estop_in;
      alarm_reg <= alarm_in;
    end
  end

  assign base_enable_out     = base_reg;
  assign ready_out           = ready_reg;
  assign brake_interlock_out = mbr_reg;
  assign zero_speed_out      = zsp_reg;
  assign dyn_brake_out       = dyn_reg;
  assign estop_warning       = warn_reg;

  // Interrupt sources, one cycle each
  assign irq_ev[`SEBS_IRQ_ESTOP] = !estop_in && !warn_reg;
  assign irq_ev[`SEBS_IRQ_ALARM] = alarm_in && !alarm_reg;
  assign irq_ev[`SEBS_IRQ_READY] = ready_next && !ready_reg;
  assign irq_ev[`SEBS_IRQ_COAST] = !base_next && base_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      func_sel_reg  <= `SEBS_FUNC_SEL_RST;
      brake_dly_reg <= BDW'(`SEBS_BRAKE_DLY_RST);
      irq_mask_reg  <= `SEBS_IRQ_MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == `SEBS_OFF_FUNC_SEL) begin
        func_sel_reg <= reg_wdata[15:0];
      end
      if (reg_addr == `SEBS_OFF_BRAKE_DLY) begin
        brake_dly_reg <= reg_wdata[BDW-1:0];
      end
      if (reg_addr == `SEBS_OFF_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata[`SEBS_IRQ_N-1:0];
      end
    end
  end

  // A new event beats a write-one clear in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_reg <= '0;
    end else if (reg_wr && reg_addr == `SEBS_OFF_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~reg_wdata[`SEBS_IRQ_N-1:0]) | irq_ev;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_ev;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `SEBS_OFF_FUNC_SEL:  reg_rdata <= {16'h0000, func_sel_reg};
        `SEBS_OFF_BRAKE_DLY: reg_rdata <= 32'(brake_dly_reg);
        `SEBS_OFF_STATUS: begin
          reg_rdata <= {23'h000000, alarm_reg, warn_reg, dyn_reg, mbr_reg,
                        ready_reg, base_reg, st_reg};
        end
        `SEBS_OFF_IRQ_STAT:  reg_rdata <= 32'(irq_stat_reg);
        `SEBS_OFF_IRQ_MASK:  reg_rdata <= 32'(irq_mask_reg);
        default:             reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Checks
  logic [TW-1:0] on_cnt_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      on_cnt_reg <= '0;
    end else begin
      on_cnt_reg <= base_reg ? on_cnt_reg + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_locked_off;
    (st_reg == sebs_pkg::SEBS_ST_RUN) && !servo_enable_in && !fault;
  endsequence

  sequence s_brake_hold;
    base_reg && !mbr_reg;
  endsequence

  holdoff_base_a: assert property (
    (st_reg == sebs_pkg::SEBS_ST_HOLDOFF) |-> !base_reg && !ready_reg)
    else $error("power stage on during power-up holdoff");

  ready_delay_a: assert property (
    $rose(ready_reg) |-> base_reg && on_cnt_reg == READY_LD + 1'b1)
    else $error("ready not one ready delay after power stage on");

  reset_base_a: assert property (
    drive_reset_in |=> !base_reg)
    else $error("power stage on while drive reset held");

  estop_brake_a: assert property (
    !estop_in |=> dyn_reg && warn_reg && !base_reg)
    else $error("estop did not brake and warn");

  estop_resume_a: assert property (
    $rose(estop_in) && servo_enable_in && !alarm_in && !drive_reset_in
    && st_reg == sebs_pkg::SEBS_ST_OFF |=> base_reg)
    else $error("no restart after estop cleared");

  pin_select_a: assert property (
    mbr_sel |=> !zero_speed_out)
    else $error("zero speed shown while brake interlock selected");

  brake_hold_a: assert property (
    s_locked_off ##0 mbr_sel |=> s_brake_hold)
    else $error("servo lock not kept at servo-off");

  coast_nobrake_a: assert property (
    s_locked_off ##0 !mbr_sel |=> !base_reg ##1 !base_reg)
    else $error("no coast at servo-off without brake");

  alarm_stop_a: assert property (
    alarm_in |=> !base_reg && dyn_reg)
    else $error("alarm did not stop power stage");

  ready_off_a: assert property (
    !base_reg |-> !ready_reg)
    else $error("ready high with power stage off");

endmodule
`default_nettype wire

// ===== verif/sebs_ctrl_model.sv
// Behavioural model of the outside controller and machine safety sequence
`default_nettype none
module sebs_ctrl_model (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic run_req,
  input  wire logic obey_estop,
  input  wire logic estop_in,
  input  wire logic dyn_brake_out,
  input  wire logic estop_warning,
  output logic      servo_enable_in,
  output logic      contactor_open
);
  timeunit 1ns;
  timeprecision 1ps;
  // Run command withdrawn while estop open; obey_estop low only to test resume
  assign servo_enable_in = run_req & (estop_in | ~obey_estop);
  // Dynamic brake without estop means the drive has an alarm
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      contactor_open <= 1'b0;
    end else if (dyn_brake_out && !estop_warning) begin
      contactor_open <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== verif/test_servo_enable_brake_sequencer.sv
// Self-checking bench for the servo enable and brake sequencer
`include "sebs_cfg.svh"
`default_nettype none
module test_servo_enable_brake_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 50;
  localparam int RDY  = 10;
  localparam int MS   = 5;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        run_req = 1'b1;
  logic        obey = 1'b1;
  logic        servo_enable_in;
  logic        drive_reset_in = 1'b0;
  logic        estop_in = 1'b1;
  logic        alarm_in = 1'b0;
  logic        zero_speed_in = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        base_enable_out, ready_out, dyn_brake_out, estop_warning;
  logic        brake_interlock_out, zero_speed_out, irq, contactor_open;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n;

  sebs_top #(.HOLDOFF_CYC(HOLD), .READY_CYC(RDY), .MS_CYC(MS)) DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .servo_enable_in(servo_enable_in),
    .drive_reset_in(drive_reset_in), .estop_in(estop_in), .alarm_in(alarm_in),
    .zero_speed_in(zero_speed_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .base_enable_out(base_enable_out), .ready_out(ready_out),
    .dyn_brake_out(dyn_brake_out), .estop_warning(estop_warning),
    .brake_interlock_out(brake_interlock_out), .zero_speed_out(zero_speed_out),
    .irq(irq));
  sebs_ctrl_model u_ctrl (
    .clk_sys(clk_sys), .arst_n(arst_n), .run_req(run_req), .obey_estop(obey),
    .estop_in(estop_in), .dyn_brake_out(dyn_brake_out), .estop_warning(estop_warning),
    .servo_enable_in(servo_enable_in), .contactor_open(contactor_open));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Ceiling well above the fewer than two hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(logic [31:0] seen, logic [31:0] exp, string msg);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: saw %h want %h", $time, msg, seen, exp);
    end
  endtask
  // Reads at an edge see the values settled before it
  task automatic step(int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    step(1);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    step(1);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, string msg);
    step(1);
    reg_rd <= 1'b1;
    reg_addr <= a;
    step(1);
    reg_rd <= 1'b0;
    step(1);
    chk(reg_rdata, e, msg);
  endtask
  task automatic wait_base(logic v, string msg);
    int k;
    k = 0;
    while (base_enable_out !== v && k < 40) begin
      step(1);
      k++;
    end
    chk(base_enable_out, v, msg);
  endtask

  task automatic t_power_on();
    rd(8'h00, 32'h0, "func sel reset");
    rd(8'h04, 32'h0, "brake delay reset");
    rd(8'h10, 32'h0, "irq mask reset");
    rd(8'h14, 32'h0, "unmapped read");
    step(HOLD - 20);
    chk(base_enable_out, 1'b0, "base during holdoff");
    wait_base(1'b1, "base after holdoff");
    step(RDY);
    chk(ready_out, 1'b0, "ready early");
    step(1);
    chk(ready_out, 1'b1, "ready late");
    $display("power-on test done");
  endtask
  task automatic t_reset();
    drive_reset_in <= 1'b1;
    step(2);
    chk({base_enable_out, ready_out}, 2'b00, "reset holds base off");
    step(3);
    chk(base_enable_out, 1'b0, "base still off");
    drive_reset_in <= 1'b0;
    wait_base(1'b1, "base after reset");
    $display("reset test done");
  endtask
  task automatic t_estop();
    obey <= 1'b0;
    // One press and one release only, no stop/run toggling
    estop_in <= 1'b0;
    step(2);
    chk({base_enable_out, dyn_brake_out, estop_warning}, 3'b011, "estop");
    // Off state, dynamic brake and warning set, power stage clear
    rd(8'h08, 32'h000000c1, "status during estop");
    estop_in <= 1'b1;
    step(3);
    chk(base_enable_out, 1'b1, "resume after estop");
    obey <= 1'b1;
    $display("estop test done");
  endtask
  task automatic t_alarm();
    wr(8'h0c, 32'hf);
    alarm_in <= 1'b1;
    step(2);
    chk({base_enable_out, dyn_brake_out}, 2'b01, "alarm stop");
    step(1);
    chk(irq, 1'b0, "masked irq");
    chk(contactor_open, 1'b1, "contactor opened");
    wr(8'h10, 32'h2);
    step(1);
    chk(irq, 1'b1, "unmasked irq");
    wr(8'h0c, 32'h2);
    step(1);
    chk(irq, 1'b0, "irq cleared");
    alarm_in <= 1'b0;
    wait_base(1'b1, "base after alarm");
    $display("alarm test done");
  endtask
  task automatic t_brake();
    wr(8'h00, 32'h0000dd1d);
    wr(8'h04, 32'h2);
    zero_speed_in <= 1'b1;
    step(3);
    chk(zero_speed_out, 1'b0, "zero speed gone");
    step(RDY + 3);
    chk(brake_interlock_out, 1'b1, "interlock released");
    run_req <= 1'b0;
    step(2);
    chk({brake_interlock_out, ready_out}, 2'b00, "interlock engaged");
    n = 0;
    while (base_enable_out === 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    chk(n >= 2 * MS - 1 && n <= 3 * MS + 2, 1'b1, "brake delay length");
    $display("brake test done");
  endtask
  task automatic t_coast();
    wr(8'h00, 32'h0);
    step(3);
    chk(zero_speed_out, 1'b1, "zero speed back");
    run_req <= 1'b1;
    wait_base(1'b1, "base on");
    // Servo-off must come from the run state to exercise the plain coast
    step(RDY + 3);
    chk(ready_out, 1'b1, "ready before servo-off");
    run_req <= 1'b0;
    step(2);
    chk({base_enable_out, ready_out}, 2'b00, "coast at once");
    $display("coast test done");
  endtask

  initial begin
    step(12);
    arst_n <= 1'b1;
    t_power_on();
    t_reset();
    t_estop();
    t_alarm();
    t_brake();
    t_coast();
    test_done();
  end
endmodule
`default_nettype wire
